// ### hw/swt_device.sv
// charger end: smbus slave, watchdog and bus release timeout
`timescale 1ns/1ps
`default_nettype none
module swt_device
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // smbus pins
  swt_if.device            bus,
  // charge control side
  input  wire logic        wd_kick,
  output logic             wd_expired,
  output logic [15:0]      charge_option,
  output logic             bus_timeout
);
  typedef enum logic [2:0] {SWT_IDLE, SWT_RX, SWT_ACK, SWT_TX, SWT_TACK, SWT_WAIT} swt_st_e;
  swt_st_e     st_reg;
  logic [17:0] div_reg;
  logic        ms_tick;
  logic        scl_d, sda_d;
  logic        scl_rise, scl_fall, start_c, stop_c;
  logic [3:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic [1:0]  byte_reg;
  logic        rd_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  lo_reg;
  logic        acking_reg;
  logic [15:0] charge_option_reg;
  logic [5:0]  low_ms_reg;
  logic [5:0]  kick_ms_reg;
  logic [17:0] wd_cnt_reg;
  logic        kick_ok;
  logic        per_chg;

  // millisecond enable pulse
  // one shared tick keeps every long timer narrow
  always_ff @(posedge mclk or posedge rst)
    if (rst) div_reg <= 18'h0;
    else if (div_reg == swt_pkg::MS_DIV_LAST) div_reg <= 18'h0;
    else div_reg <= div_reg + 18'h1;
  assign ms_tick = (div_reg == swt_pkg::MS_DIV_LAST);

  // edge detection on the pins
  // history resets to the idle high level so no false edge follows reset
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= bus.scl;
      sda_d <= bus.sda;
    end
  assign scl_rise = bus.scl & ~scl_d;
  assign scl_fall = ~bus.scl & scl_d;
  assign start_c  = bus.scl & scl_d & sda_d & ~bus.sda;
  assign stop_c   = bus.scl & scl_d & ~sda_d & bus.sda;

  // clock low timer, any single low phase
  // whole ticks only: the flag shows between 25 and 26 ms after the fall
  always_ff @(posedge mclk or posedge rst)
    if (rst) low_ms_reg <= 6'h0;
    else if (bus.scl) low_ms_reg <= 6'h0;
    else if (ms_tick && low_ms_reg != swt_pkg::TIMEOUT_TICKS) low_ms_reg <= low_ms_reg + 6'h1;
  assign bus_timeout = (low_ms_reg == swt_pkg::TIMEOUT_TICKS); // RQ1

  // byte engine: nine clocks per byte, ack on the ninth
  // a timeout or stop wins over a start seen in the same cycle
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      st_reg <= SWT_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h0;
      byte_reg <= 2'h0;
      rd_reg <= 1'b0;
      acking_reg <= 1'b0;
    end
    else if (bus_timeout || stop_c)
    begin
      st_reg <= SWT_IDLE; // RQ2
      acking_reg <= 1'b0;
    end
    else if (start_c)
    begin
      st_reg <= SWT_RX;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      acking_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        SWT_RX:
          if (scl_rise)
          begin
            sh_reg <= {sh_reg[6:0], bus.sda}; // RQ10
            bit_reg <= bit_reg + 4'h1;
          end
          else if (scl_fall && bit_reg == 4'h8)
          begin
            bit_reg <= 4'h0;
            st_reg <= SWT_ACK;
            // address byte must match, data bytes always acked
            if (byte_reg == 2'h0 && sh_reg[7:1] != swt_pkg::DEV_ADDR) st_reg <= SWT_WAIT;
            else acking_reg <= 1'b1;
            if (byte_reg == 2'h0) rd_reg <= sh_reg[0];
          end
        SWT_ACK:
          if (scl_fall)
          begin
            acking_reg <= 1'b0;
            byte_reg <= (byte_reg == 2'h3) ? 2'h3 : byte_reg + 2'h1;
            st_reg <= rd_reg ? SWT_TX : SWT_RX; // RQ9
            sh_reg <= cmd_reg == swt_pkg::CMD_CHG_OPT ? charge_option_reg[7:0] : 8'h0;
          end
        SWT_TX:
          if (scl_fall)
          begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7)
            begin
              bit_reg <= 4'h0;
              st_reg <= SWT_TACK;
            end
          end
        SWT_TACK:
          // master nack at the clock rise ends the read; on an ack the high
          // byte loads at the fall, as a load at the rise would lose its msb
          // to the shift on that same fall
          if (scl_rise && bus.sda) st_reg <= SWT_WAIT; // RQ9
          else if (scl_fall)
          begin
            st_reg <= SWT_TX; // RQ9
            sh_reg <= cmd_reg == swt_pkg::CMD_CHG_OPT ? charge_option_reg[15:8] : 8'h0;
          end
        default: ;
      endcase
    end

  // command and data capture
  // words for other command codes are acked and dropped
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      cmd_reg <= 8'h0;
      lo_reg <= 8'h0;
      charge_option_reg <= swt_pkg::CHG_OPT_RESET; // RQ6
    end
    else if (st_reg == SWT_RX && scl_fall && bit_reg == 4'h8 && !rd_reg && !bus_timeout)
    begin
      if (byte_reg == 2'h1) cmd_reg <= sh_reg;
      if (byte_reg == 2'h2) lo_reg <= sh_reg;
      if (byte_reg == 2'h3 && cmd_reg == swt_pkg::CMD_CHG_OPT)
        charge_option_reg <= {sh_reg, lo_reg}; // RQ8
    end
  assign charge_option = charge_option_reg;

  // pin drive; released at once on timeout
  // never stretching leaves the whole stretch budget to the master
  assign bus.scl_o_s  = 1'b1;
  assign bus.scl_oe_s = 1'b0; // RQ3
  assign bus.sda_o_s  = 1'b0;
  assign bus.sda_oe_s = ~bus_timeout & (acking_reg | (st_reg == SWT_TX & ~sh_reg[7])); // RQ2

  // kick deglitch; the first tick may follow the kick at once, so the
  // restart waits one tick past the limit to cover the full interval
  // the count parks one above the limit so a held kick restarts only once
  always_ff @(posedge mclk or posedge rst)
    if (rst) kick_ms_reg <= 6'h0;
    else if (!wd_kick) kick_ms_reg <= 6'h0;
    else if (ms_tick && kick_ms_reg != swt_pkg::DEGLITCH_TICKS + 6'h1)
      kick_ms_reg <= kick_ms_reg + 6'h1;
  assign kick_ok = ms_tick && wd_kick && kick_ms_reg == swt_pkg::DEGLITCH_TICKS; // RQ7

  // watchdog counter
  // code 00 parks the counter; a restart wins over a tick in the same cycle
  assign per_chg = (st_reg == SWT_RX && scl_fall && bit_reg == 4'h8 && !rd_reg && !bus_timeout
                    && byte_reg == 2'h3 && cmd_reg == swt_pkg::CMD_CHG_OPT
                    && sh_reg[swt_pkg::WD_MSB-8:swt_pkg::WD_LSB-8]
                       != charge_option_reg[swt_pkg::WD_MSB:swt_pkg::WD_LSB]);
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wd_cnt_reg <= 18'h0;
      wd_expired <= 1'b0;
    end
    else
    begin
      wd_expired <= 1'b0;
      if (kick_ok || per_chg) wd_cnt_reg <= 18'h0; // RQ11
      else if (charge_option_reg[swt_pkg::WD_MSB:swt_pkg::WD_LSB] == swt_pkg::WD_CODE_OFF)
        wd_cnt_reg <= 18'h0;
      else if (ms_tick)
      begin
        if (wd_cnt_reg
            == swt_pkg::wd_ticks(charge_option_reg[swt_pkg::WD_MSB:swt_pkg::WD_LSB]) - 18'h1)
        begin
          wd_cnt_reg <= 18'h0;
          wd_expired <= 1'b1; // RQ4 RQ5 RQ6 RQ11
        end
        else wd_cnt_reg <= wd_cnt_reg + 18'h1;
      end
    end
endmodule : swt_device
`default_nettype wire

// ### hw/swt_host.sv
// controller end: smbus master doing word writes and reads
`timescale 1ns/1ps
`default_nettype none
module swt_host
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // smbus pins
  swt_if.host              bus,
  // user request
  input  wire logic        req,
  input  wire logic        req_read,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [15:0] req_wdata,
  output logic             busy,
  output logic             done,
  output logic             nacked,
  output logic [15:0]      rdata
);
  typedef enum logic [2:0] {SWH_IDLE, SWH_START, SWH_BIT, SWH_STOP} swh_st_e;
  swh_st_e     st_reg;
  logic [11:0] ph_reg;
  logic [1:0]  q_reg;
  logic [3:0]  bit_reg;
  logic [2:0]  byte_reg;
  logic [7:0]  sh_reg;
  logic        rd_reg;
  logic [7:0]  cmd_reg;
  logic [15:0] wd_reg;
  logic        scl_reg, sda_reg;
  logic        tick;
  logic [2:0]  last_byte;

  assign tick = (ph_reg == swt_pkg::HALF_BIT);
  // bytes: addr w, cmd, lo, hi; read: addr w, cmd, addr r, lo, hi
  assign last_byte = rd_reg ? 3'h4 : 3'h3; // RQ9

  // quarter phase timer; clock never held low beyond a bit, well under 10 ms
  always_ff @(posedge mclk or posedge rst)
    if (rst) ph_reg <= 12'h0;
    else if (st_reg == SWH_IDLE || tick) ph_reg <= 12'h0;
    else ph_reg <= ph_reg + 12'h1; // RQ3

  // sequencer
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      st_reg <= SWH_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      byte_reg <= 3'h0;
      sh_reg <= 8'h0;
      rd_reg <= 1'b0;
      cmd_reg <= 8'h0;
      wd_reg <= 16'h0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      done <= 1'b0;
      nacked <= 1'b0;
      rdata <= 16'h0;
    end
    else
    begin
      done <= 1'b0;
      case (st_reg)
        SWH_IDLE:
          if (req)
          begin
            rd_reg <= req_read;
            cmd_reg <= req_cmd;
            wd_reg <= req_wdata;
            byte_reg <= 3'h0;
            nacked <= 1'b0;
            q_reg <= 2'h0;
            st_reg <= SWH_START;
          end
        SWH_START:
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0)
            begin
              scl_reg <= 1'b1;
              sda_reg <= 1'b1;
            end
            else if (q_reg == 2'h1) sda_reg <= 1'b0;
            else
            begin
              scl_reg <= 1'b0;
              st_reg <= SWH_BIT;
              bit_reg <= 4'h0;
              q_reg <= 2'h0;
              sh_reg <= (rd_reg && byte_reg == 3'h2) ? {swt_pkg::DEV_ADDR, 1'b1}
                                                     : {swt_pkg::DEV_ADDR, 1'b0};
            end
          end
        SWH_BIT:
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0)
            begin
              // drive data while clock is low; ack slot set by direction
              if (bit_reg == 4'h8)
                sda_reg <= ~(rd_reg && byte_reg >= 3'h3) ? 1'b1 : (byte_reg == last_byte);
              else sda_reg <= (rd_reg && byte_reg >= 3'h3) ? 1'b1 : sh_reg[7];
            end
            else if (q_reg == 2'h1) scl_reg <= 1'b1;
            else if (q_reg == 2'h2)
            begin
              if (bit_reg == 4'h8)
              begin
                if (~(rd_reg && byte_reg >= 3'h3) && bus.sda) nacked <= 1'b1;
              end
              else sh_reg <= {sh_reg[6:0], bus.sda}; // RQ10
            end
            else
            begin
              scl_reg <= 1'b0;
              q_reg <= 2'h0;
              if (bit_reg != swt_pkg::BITS_PER_BYTE - 4'h1) bit_reg <= bit_reg + 4'h1;
              else
              begin
                bit_reg <= 4'h0;
                if (rd_reg && byte_reg == 3'h3) rdata[7:0] <= sh_reg;
                if (rd_reg && byte_reg == 3'h4) rdata[15:8] <= sh_reg;
                byte_reg <= byte_reg + 3'h1;
                if (nacked || byte_reg == last_byte) st_reg <= SWH_STOP;
                else if (rd_reg && byte_reg == 3'h1) st_reg <= SWH_START; // RQ9
                else
                  case (byte_reg)
                    3'h0: sh_reg <= cmd_reg;
                    3'h1: sh_reg <= wd_reg[7:0];
                    3'h2: sh_reg <= wd_reg[15:8];
                    default: sh_reg <= 8'h0;
                  endcase
              end
            end
          end
        SWH_STOP:
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0) sda_reg <= 1'b0;
            else if (q_reg == 2'h1) scl_reg <= 1'b1;
            else
            begin
              sda_reg <= 1'b1;
              st_reg <= SWH_IDLE;
              done <= 1'b1;
              q_reg <= 2'h0;
            end
          end
        default: st_reg <= SWH_IDLE;
      endcase
    end

  assign busy = (st_reg != SWH_IDLE);
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = ~scl_reg;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = ~sda_reg;
endmodule : swt_host
`default_nettype wire

// ### inc/swt_if.sv
// smbus wires between the embedded controller and the charger
`timescale 1ns/1ps
`default_nettype none
interface swt_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic scl_o_s;
  logic scl_oe_s;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // open drain wired and; enables pull low
  assign scl = ~((scl_oe_m & ~scl_o_m) | (scl_oe_s & ~scl_o_s));
  assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));
  modport host (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m,
                input scl, input sda);
  modport device (output scl_o_s, output scl_oe_s, output sda_o_s, output sda_oe_s,
                  input scl, input sda);
endinterface : swt_if
`default_nettype wire

// ### inc/swt_pkg.sv
// shared constants for the smbus watchdog and bus timeout ends
//
// Contract
// RQ1: clock low over 25 ms means timeout
// RQ2: on timeout idle, release data by 35 ms
// RQ3: master stretch 10 ms, slave 25 ms total
// RQ4: field bits 14:13, code 01 gives 44 s
// RQ5: code 10 gives 88 s watchdog expiry
// RQ6: code 11 is reset value, 175 s
// RQ7: reset event deglitched at least 10 ms
// RQ8: host writes period via command 0x12
// RQ9: word write, read with repeated start, nack
// RQ10: nine clocks per byte, ack ninth
// RQ11: one expiry pulse, restart on kick or change
`default_nettype none
package swt_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned TIMEOUT_MIN_MS = 25;
  localparam int unsigned TIMEOUT_MAX_MS = 35;
  localparam int unsigned MSTR_STRETCH_MS = 10;
  localparam int unsigned SLV_STRETCH_MS = 25;
  localparam int unsigned DEGLITCH_MS    = 10;
  localparam int unsigned WD_01_S        = 44;
  localparam int unsigned WD_10_S        = 88;
  localparam int unsigned WD_11_S        = 175;
  // millisecond tick divider
  localparam int unsigned MS_DIV         = CLK_HZ / 1000;
  localparam logic [17:0] MS_DIV_LAST    = 18'(MS_DIV - 1);
  // timeout declared just past 25 ms, well inside the 35 ms release bound
  localparam logic [5:0]  TIMEOUT_TICKS  = 6'(TIMEOUT_MIN_MS + 1);
  localparam logic [5:0]  DEGLITCH_TICKS = 6'(DEGLITCH_MS);
  localparam logic [5:0]  MSTR_STRETCH_TICKS = 6'(MSTR_STRETCH_MS);
  localparam logic [5:0]  SLV_STRETCH_TICKS  = 6'(SLV_STRETCH_MS);
  // device addressing
  localparam logic [6:0]  DEV_ADDR       = 7'h09;
  localparam logic [7:0]  CMD_CHG_OPT    = 8'h12;
  localparam int unsigned WD_LSB         = 13;
  localparam int unsigned WD_MSB         = 14;
  localparam logic [15:0] CHG_OPT_RESET  = 16'h7912;
  localparam logic [1:0]  WD_CODE_OFF    = 2'h0;
  localparam logic [1:0]  WD_CODE_01     = 2'h1;
  localparam logic [1:0]  WD_CODE_10     = 2'h2;
  localparam logic [1:0]  WD_CODE_11     = 2'h3;
  // millisecond ticks for each period code
  function automatic logic [17:0] wd_ticks(input logic [1:0] code);
    case (code)
      WD_CODE_01: wd_ticks = 18'(WD_01_S * 1000);
      WD_CODE_10: wd_ticks = 18'(WD_10_S * 1000);
      default:    wd_ticks = 18'(WD_11_S * 1000);
    endcase
  endfunction : wd_ticks
  // master timing: quarter bit in mclk cycles, about 1.5 MHz; kept fast so a
  // frame takes a few thousand cycles, a real bus must run far slower
  localparam logic [11:0] HALF_BIT       = 12'h020;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h9;
endpackage : swt_pkg
`default_nettype wire

// ### verification/smbus_watchdog_timeout_tb.sv
// testbench joining controller and charger ends over the smbus wires
`timescale 1ns/1ps
`default_nettype none
module smbus_watchdog_timeout_tb;
  logic        mclk, rst, req, req_read, wd_kick;
  logic        busy, done, nacked, wd_expired, bus_timeout;
  logic [7:0]  req_cmd;
  logic [15:0] req_wdata, rdata, charge_option;
  int          err_count, n_checks;
  int unsigned mdl_opt;
  int unsigned exp_q[$];
  swt_if bus_if ();
  swt_host u_swt_host (.mclk(mclk), .rst(rst), .bus(bus_if), .req(req), .req_read(req_read),
    .req_cmd(req_cmd), .req_wdata(req_wdata), .busy(busy), .done(done), .nacked(nacked),
    .rdata(rdata));
  swt_device u_swt_device (.mclk(mclk), .rst(rst), .bus(bus_if), .wd_kick(wd_kick),
    .wd_expired(wd_expired), .charge_option(charge_option), .bus_timeout(bus_timeout));
  swt_properties u_swt_properties (.mclk(mclk), .rst(rst), .scl_o_m(bus_if.scl_o_m),
    .scl_oe_m(bus_if.scl_oe_m), .sda_o_m(bus_if.sda_o_m), .sda_oe_m(bus_if.sda_oe_m),
    .scl_o_s(bus_if.scl_o_s), .scl_oe_s(bus_if.scl_oe_s), .sda_o_s(bus_if.sda_o_s),
    .sda_oe_s(bus_if.sda_oe_s), .scl(bus_if.scl), .sda(bus_if.sda));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // one word frame; the model predicts the register and read data
  task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] wd);
    int n;
    if (rd)
      exp_q.push_back((cmd == swt_pkg::CMD_CHG_OPT) ? mdl_opt : 0);
    else if (cmd == swt_pkg::CMD_CHG_OPT)
      mdl_opt = wd;
    @(posedge mclk);
    req <= 1'b1;
    req_read <= rd;
    req_cmd <= cmd;
    req_wdata <= wd;
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    req <= 1'b0;
    // a write frame takes some five thousand cycles and a read some six thousand at the host bit rate
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge mclk);
      n++;
    end
    if (done !== 1'b1)
    begin
      err_count++;
      $display("ERROR %0t frame did not complete", $time);
    end
    check({15'h0, busy}, 16'h0000);
    check({15'h0, nacked}, 16'h0000);
    check({15'h0, bus_timeout}, 16'h0000);
    check(charge_option, mdl_opt[15:0]);
    if (rd)
      check(rdata, 16'(exp_q.pop_front()));
  endtask : xfer
  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // expiry needs tens of seconds, so it must never show in this run
  always @(negedge mclk)
    if (!rst && wd_expired !== 1'b0)
    begin
      err_count++;
      $display("ERROR %0t early watchdog expiry", $time);
    end
  // hang guard: seven frames and the kicks need under 45k cycles, so
  // 80k cycles means the run is stuck
  initial
  begin
    #(400_000);
    err_count++;
    $display("ERROR %0t run did not finish", $time);
    results();
  end
  initial
  begin
    logic [15:0] wd;
    rst = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    req_cmd = 8'h00;
    req_wdata = 16'h0000;
    wd_kick = 1'b0;
    err_count = 0;
    n_checks = 0;
    mdl_opt = swt_pkg::CHG_OPT_RESET;
    void'($urandom(32'h2c845dd4));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check({14'h0, charge_option[14:13]}, 16'h0003);
    xfer(1'b1, 8'h12, 16'h0000);
    // every period code, with a short kick that the deglitch must ignore
    for (int c = 1; c < 5; c++)
    begin
      wd = 16'($urandom);
      wd[14:13] = 2'(c);
      @(posedge mclk);
      wd_kick <= 1'b1;
      repeat ($urandom_range(1, 1000)) @(posedge mclk);
      wd_kick <= 1'b0;
      xfer(1'b0, 8'h12, wd);
    end
    xfer(1'b1, 8'h12, 16'h0000);
    xfer(1'b1, 8'($urandom_range(8'h13, 8'hfd)), 16'h0000);
    results();
  end
endmodule : smbus_watchdog_timeout_tb
`default_nettype wire

// ### verification/swt_properties.sv
// bus checks on the smbus wires between the two ends
`timescale 1ns/1ps
`default_nettype none
module swt_properties
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // smbus drivers and wires
  input wire logic scl_o_m,
  input wire logic scl_oe_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_m,
  input wire logic scl_o_s,
  input wire logic scl_oe_s,
  input wire logic sda_o_s,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  localparam int unsigned MS_CYC   = swt_pkg::CLK_HZ / 1000;
  localparam int unsigned MSTR_CYC = swt_pkg::MSTR_STRETCH_MS * MS_CYC;
  localparam int unsigned REL_CYC  = swt_pkg::TIMEOUT_MAX_MS * MS_CYC;
  int unsigned low_cnt;
  logic [3:0]  bit_cnt;
  logic        scl_q;
  logic        sda_q;
  logic        in_frame;
  wire         start_c = scl && scl_q && sda_q && !sda;
  wire         stop_c  = scl && scl_q && !sda_q && sda;
  // open drain: an enabled driver may only pull low
  wire         drive_low = (!scl_oe_m || !scl_o_m) && (!sda_oe_m || !sda_o_m)
                           && (!scl_oe_s || !scl_o_s) && (!sda_oe_s || !sda_o_s);
  // length of the current clock low phase
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      low_cnt <= 0;
    else
      low_cnt <= scl ? 0 : low_cnt + 1;
  // previous wire levels for start and stop detection
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      {scl_q, sda_q} <= 2'h3;
    else
      {scl_q, sda_q} <= {scl, sda};
  // clock rises mod nine; the rise before stop or restart leaves it at one
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      bit_cnt <= 4'h0;
    else if (start_c)
      bit_cnt <= 4'h0;
    else if (scl && !scl_q)
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
  // inside a frame between start and stop
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      in_frame <= 1'b0;
    else if (start_c || stop_c)
      in_frame <= start_c;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_slave_no_stretch: assert property (!scl_oe_s)
    else $error("device pulled the clock low");
  a_master_stretch: assert property (low_cnt <= MSTR_CYC)
    else $error("clock low beyond the master stretch limit");
  a_dev_sda_release: assert property (low_cnt >= REL_CYC |-> !sda_oe_s)
    else $error("device still holds data after the release bound");
  a_host_sda_release: assert property (low_cnt >= REL_CYC |-> !sda_oe_m)
    else $error("controller still holds data after the release bound");
  a_dev_sda_edge: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("device moved data while the clock was high");
  a_sda_hold_high: assert property ($rose(scl) |-> ##1 $stable(sda) [*4])
    else $error("data moved right after a clock rise");
  a_stop_on_byte: assert property (stop_c && in_frame |-> bit_cnt == 4'h1)
    else $error("stop not on a nine clock byte boundary");
  a_rstart_on_byte: assert property (start_c && in_frame |-> bit_cnt == 4'h1)
    else $error("repeated start not on a byte boundary");
  a_idle_after_rst: assert property ($fell(rst) |-> !sda_oe_m && !sda_oe_s && !scl_oe_m)
    else $error("pins not released out of reset");
  a_drive_low_only: assert property (drive_low)
    else $error("a driver was enabled with a high level");
  // main scenarios reached
  c_start: cover property (start_c && !in_frame);
  c_rstart: cover property (start_c && in_frame);
  c_stop: cover property (stop_c && in_frame);
  c_dev_drive: cover property ($rose(sda_oe_s));
endmodule : swt_properties
`default_nettype wire
